// ===== cpr_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module cpr_ctrl
   import cpr_pkg::*;
#(
   parameter int RL = CPR_RL_DEF
) (
   input  wire logic        core_clk,
   input  wire logic        reset,
   cpr_link_if.ctrl         link,
   input  wire logic        cal_start,
   input  wire logic [1:0]  cal_count,
   input  wire logic        cal_chop,
   output logic             cal_busy,
   output logic [15:0]      beat_data,
   output logic             beat_valid,
   input  wire logic        beat_ready
);
   typedef enum logic [6:0] {
      CPR_IDLE = 7'h01, CPR_PRE = 7'h02, CPR_ENT = 7'h04, CPR_RD = 7'h08,
      CPR_REC  = 7'h10, CPR_EXIT = 7'h20, CPR_WAIT = 7'h40
   } cpr_state_t;
   cpr_state_t  state_reg;
   logic [7:0]  wait_reg;
   logic [1:0]  left_reg;
   logic        nib_reg;
   logic        fifo_ready;
   logic        cap_valid;
   // ==========================================================
   // Sequencer; lock comes from same-clock logic and is read directly
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_reg      <= CPR_IDLE;
         wait_reg       <= '0;
         left_reg       <= '0;
         nib_reg        <= 1'b0;
         link.cmd       <= CPR_CMD_NOP;
         link.cmd_valid <= 1'b0;
         link.ba        <= '0;
         link.addr      <= '0;
         cal_busy       <= 1'b0;
      end else begin
         link.cmd_valid <= 1'b0;
         link.cmd       <= CPR_CMD_NOP;
         if (wait_reg != '0) begin
            wait_reg <= wait_reg - 8'h01;
         end else begin
            unique case (state_reg)
               CPR_IDLE: begin
                  if (cal_start && link.dll_locked) begin
                     cal_busy       <= 1'b1;
                     link.cmd       <= CPR_CMD_PREA;
                     link.cmd_valid <= 1'b1;
                     wait_reg       <= 8'(CPR_TRP);
                     left_reg       <= cal_count;
                     state_reg      <= CPR_PRE;
                  end
               end
               CPR_PRE: begin
                  // Length picked per read by A12, so chopping needs no mode change
                  link.cmd       <= CPR_CMD_MRS;
                  link.cmd_valid <= 1'b1;
                  link.ba        <= CPR_MR0;
                  link.addr      <= {11'h000, CPR_BL_OTF};
                  wait_reg       <= 8'(CPR_TMRD);
                  state_reg      <= CPR_ENT;
               end
               CPR_ENT: begin
                  link.cmd       <= CPR_CMD_MRS;
                  link.cmd_valid <= 1'b1;
                  link.ba        <= CPR_MR3;
                  link.addr      <= 13'h0004 | {11'h000, CPR_LOC_CAL};
                  wait_reg       <= 8'(CPR_TMRD + CPR_TMOD);
                  state_reg      <= CPR_RD;
               end
               CPR_RD: begin
                  if (fifo_ready) begin
                     link.cmd       <= CPR_CMD_RD;
                     link.cmd_valid <= 1'b1;
                     link.ba        <= '0;
                     link.addr      <= {~cal_chop, 9'h000, cal_chop & nib_reg, 2'h0};
                     nib_reg        <= ~nib_reg;
                     wait_reg       <= 8'(RL + CPR_BURST8 + 2);
                     if (left_reg == '0) begin
                        state_reg <= CPR_REC;
                     end else begin
                        left_reg <= left_reg - 2'h1;
                     end
                  end
               end
               CPR_REC: begin
                  wait_reg  <= 8'(CPR_PATTERN_READ_RECOVERY_TIME);
                  state_reg <= CPR_EXIT;
               end
               CPR_EXIT: begin
                  link.cmd       <= CPR_CMD_MRS;
                  link.cmd_valid <= 1'b1;
                  link.ba        <= CPR_MR3;
                  link.addr      <= '0;
                  wait_reg       <= 8'(CPR_TMRD + CPR_TMOD);
                  state_reg      <= CPR_WAIT;
               end
               CPR_WAIT: begin
                  cal_busy  <= 1'b0;
                  state_reg <= CPR_IDLE;
               end
               default: state_reg <= CPR_IDLE;
            endcase
         end
      end
   end
   assign link.rst_cmd = 1'b0;
   assign link.dq_in   = '0;
   // Capture beats; full FIFO holds off further reads
   assign cap_valid = link.dq_oe;
   cpr_fifo #(.WIDTH(16), .DEPTH(32)) u_fifo (
      .core_clk  (core_clk),
      .reset     (reset),
      .in_data   (link.dq_out),
      .in_valid  (cap_valid),
      .in_ready  (fifo_ready),
      .out_data  (beat_data),
      .out_valid (beat_valid),
      .out_ready (beat_ready)
   );
endmodule
`default_nettype wire

// ===== cpr_device.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - MR3 write with A2 high enters mode
// - Controller precharges all banks before entry
// - Reads come from selected pattern location
// - Controller issues only reads until exit
// - Read with auto-precharge acts as read
// - No other commands; reset still honoured
// - A2 clear means normal array access
// - Bit 0 per lane carries pattern
// - Controller keeps column A1:A0 zero
// - Eight-beat reads use A2 zero, order 0-7
// - Chopped reads: A2 picks lower/upper nibble
// - Bank and other column bits ignored
// - A12 chops on fly if MR0 allows
// - Burst starts after read latency AL+CL
// - Controller waits for DLL lock first
// - Order bit 0 is LSB, 7 MSB
// - Location zero gives 0,1,0,1 pattern
// - Controller waits mode delays after entry
// - Controller issues no writes in mode
// - Controller waits recovery before exit
// - After exit, normal commands resume
module cpr_device
   import cpr_pkg::*;
#(
   parameter int  RL        = CPR_RL_DEF,
   parameter int  DLL_LOCK  = 16,
   parameter bit  REPLICATE = 1'b1,
   parameter int  ARR_DEPTH = 32
) (
   input  wire logic core_clk,
   input  wire logic reset,
   cpr_link_if.device link,
   output logic      pattern_mode,
   output logic      array_rd_done
);
   // ==========================================================
   // Mode registers
   logic [1:0]  loc_reg;
   logic [1:0]  blmode_reg;
   logic [7:0]  lock_cnt_reg;
   logic        lock_reg;
   logic        rd_cmd;
   logic        mrs_cmd;
   logic        wr_cmd;
   logic        rst_any;

   // One decode for the read, write and mode register strobes; PREA is not decoded
   function automatic logic cmd_hit(input logic       valid,
                                    input logic [2:0] code,
                                    input logic [2:0] want);
      return valid && (code == want);
   endfunction

   assign rst_any = reset;
   // Auto-precharge half of a read is dropped; both read codes behave alike
   assign rd_cmd  = cmd_hit(link.cmd_valid, link.cmd, CPR_CMD_RD) ||
                    cmd_hit(link.cmd_valid, link.cmd, CPR_CMD_RDA);
   assign mrs_cmd = cmd_hit(link.cmd_valid, link.cmd, CPR_CMD_MRS);
   assign wr_cmd  = cmd_hit(link.cmd_valid, link.cmd, CPR_CMD_WR);

   always_ff @(posedge core_clk or posedge rst_any) begin
      if (rst_any) begin
         pattern_mode <= 1'b0;
         loc_reg      <= CPR_LOC_CAL;
         blmode_reg   <= CPR_BL_FIX8;
      end else if (link.rst_cmd) begin
         pattern_mode <= 1'b0;
      end else if (mrs_cmd) begin
         if (link.ba == CPR_MR3) begin
            pattern_mode <= link.addr[CPR_MR3_EN];
            loc_reg      <= link.addr[1:0];
         end
         if (link.ba == CPR_MR0) begin
            blmode_reg <= link.addr[CPR_MR0_BL0+1:CPR_MR0_BL0];
         end
      end
   end

   // Models DLL lock after reset so the controller can wait on it
   always_ff @(posedge core_clk or posedge rst_any) begin
      if (rst_any) begin
         lock_cnt_reg <= '0;
         lock_reg     <= 1'b0;
      end else if (lock_cnt_reg == 8'(DLL_LOCK)) begin
         lock_reg <= 1'b1;
      end else begin
         lock_cnt_reg <= lock_cnt_reg + 8'h01;
      end
   end
   assign link.dll_locked = lock_reg;

   // ==========================================================
   // Burst shaping: A2, A12 only; banks, A[1:0] and A[11:3] ignored
   logic        chop;
   logic [2:0]  start;
   logic [7:0]  pat;
   assign chop  = (blmode_reg == CPR_BL_FIX4) ||
                  (blmode_reg == CPR_BL_OTF && !link.addr[CPR_A_BC]);
   // Nibble start only matters when chopped; eight-beat reads start at beat 0
   assign start = (chop && link.addr[CPR_A_NIB]) ? 3'h4 : 3'h0;
   assign pat   = (loc_reg == CPR_LOC_CAL) ? CPR_CAL_PAT : CPR_RFU_PAT;

   // ==========================================================
   // Latency pipe: RL stages carrying a launch request
   typedef struct packed {
      logic       go;
      logic       chop;
      logic       calibration_pattern_register;
      logic [2:0] start;
      logic [7:0] pat;
      logic [4:0] col;
   } cpr_req_t;
   cpr_req_t pipe_reg [RL];
   always_ff @(posedge core_clk or posedge rst_any) begin
      if (rst_any) begin
         for (int i = 0; i < RL; i++) begin
            pipe_reg[i] <= '0;
         end
      end else if (link.rst_cmd) begin
         // A reset request drops reads still in flight
         for (int i = 0; i < RL; i++) begin
            pipe_reg[i] <= '0;
         end
      end else begin
         // Requests march one stage a cycle, so command spacing is kept
         pipe_reg[0] <= '{rd_cmd, chop, pattern_mode, start, pat, link.addr[4:0]};
         for (int i = 1; i < RL; i++) begin
            pipe_reg[i] <= pipe_reg[i-1];
         end
      end
   end

   // ==========================================================
   // Array: small word store, written in normal mode only
   // Not reset: a word reads back sensibly only after it was written
   logic [15:0] arr_reg [ARR_DEPTH];
   always_ff @(posedge core_clk) begin
      if (!pattern_mode && wr_cmd) begin
         arr_reg[link.addr[4:0]] <= link.dq_in;
      end
   end

   // ==========================================================
   // Output burst engine
   logic [3:0]  left_reg;
   logic [2:0]  beat_reg;
   logic        mpr_reg;
   logic [7:0]  pat_reg;
   logic [4:0]  col_reg;
   logic        bit_now;
   logic [15:0] lane_bits;
   cpr_req_t    head;
   assign head    = pipe_reg[RL-1];
   assign bit_now = pat_reg[beat_reg];
   // Prime bit of each byte lane carries the pattern; the rest copy it or idle low
   for (genvar g = 0; g < 16; g++) begin : g_lane
      if (g % 8 == 0) begin : g_prime
         assign lane_bits[g] = bit_now;
      end else begin : g_rest
         assign lane_bits[g] = REPLICATE ? bit_now : 1'b0;
      end
   end
   always_ff @(posedge core_clk or posedge rst_any) begin
      if (rst_any) begin
         left_reg      <= '0;
         beat_reg      <= '0;
         mpr_reg       <= 1'b0;
         pat_reg       <= '0;
         col_reg       <= '0;
         link.dq_out   <= '0;
         link.dq_oe    <= 1'b0;
         array_rd_done <= 1'b0;
      end else if (link.rst_cmd) begin
         // Burst is cut short and the bus let go at once
         left_reg      <= '0;
         link.dq_oe    <= 1'b0;
         array_rd_done <= 1'b0;
      end else begin
         array_rd_done <= 1'b0;
         if (head.go) begin
            left_reg <= head.chop ? 4'(CPR_BURST4) : 4'(CPR_BURST8);
            beat_reg <= head.start;
            mpr_reg  <= head.calibration_pattern_register;
            pat_reg  <= head.pat;
            col_reg  <= head.col;
         end else if (left_reg != '0) begin
            left_reg <= left_reg - 4'h1;
            beat_reg <= beat_reg + 3'h1;
            col_reg  <= col_reg + 5'h01;
            if (left_reg == 4'h1 && !mpr_reg) begin
               array_rd_done <= 1'b1;
            end
         end
         // Enable rises with the first beat's data, not a cycle ahead of it
         link.dq_oe <= (left_reg != '0) && !head.go;
         if (left_reg != '0 && !head.go) begin
            if (mpr_reg) begin
               link.dq_out <= lane_bits;
            end else begin
               link.dq_out <= arr_reg[col_reg];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== cpr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module cpr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [AW:0]      cnt_reg;
   logic             push;
   logic             pop;
   assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem_reg[rd_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + AW'(1);
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + AW'(1);
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// ===== cpr_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cpr_link_asserts
   import cpr_pkg::*;
#(
   parameter int RL = CPR_RL_DEF
) (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic [2:0]  cmd,
   input wire logic [2:0]  ba,
   input wire logic [12:0] addr,
   input wire logic        cmd_valid,
   input wire logic        rst_cmd,
   input wire logic [15:0] dq_out,
   input wire logic        dq_oe,
   input wire logic        dll_locked
);
   // Command edge, RL pipe stages, then the output flop
   localparam int RL_D = RL + 2;
   // ==========================================================
   // Helper state
   logic       mode_reg;
   logic [7:0] prea_reg;
   logic [7:0] mrs_reg;
   logic       mrs3;
   logic       rd;
   assign mrs3 = cmd_valid && cmd == CPR_CMD_MRS && ba == CPR_MR3;
   assign rd   = cmd_valid && (cmd == CPR_CMD_RD || cmd == CPR_CMD_RDA);
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) mode_reg <= 1'b0;
      else if (mrs3) mode_reg <= addr[CPR_MR3_EN];
   end
   // Saturating ages, so a long idle never wraps into a false failure
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) prea_reg <= 8'h00;
      else if (cmd_valid && cmd == CPR_CMD_PREA) prea_reg <= 8'h00;
      else if (prea_reg != 8'hff) prea_reg <= prea_reg + 8'h01;
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) mrs_reg <= 8'h00;
      else if (mrs3) mrs_reg <= 8'h00;
      else if (mrs_reg != 8'hff) mrs_reg <= mrs_reg + 8'h01;
   end
   // ==========================================================
   // Properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence s_pair;
      dq_oe && dq_out == 16'h0000 ##1 dq_oe && dq_out == 16'hffff;
   endsequence
   sequence s_nibble;
      s_pair ##1 s_pair;
   endsequence
   property p_pattern;
      rd && mode_reg |-> ##RL_D s_nibble;
   endproperty
   a_pattern: assert property (p_pattern)
      else $error("pattern burst wrong or late");
   property p_burst_len;
      $rose(dq_oe) |-> dq_oe [*4] ##1 (!dq_oe or (dq_oe [*4] ##1 !dq_oe));
   endproperty
   a_burst_len: assert property (p_burst_len)
      else $error("burst length not four or eight");
   property p_alternate;
      mode_reg && dq_oe && $past(dq_oe) |-> dq_out == ~$past(dq_out);
   endproperty
   a_alternate: assert property (p_alternate)
      else $error("pattern beats do not alternate");
   property p_precharged;
      mrs3 && addr[CPR_MR3_EN] |-> prea_reg >= 8'(CPR_TRP - 1);
   endproperty
   a_precharged: assert property (p_precharged)
      else $error("mode entry too soon after precharge");
   property p_entry_wait;
      rd && mode_reg |-> mrs_reg >= 8'(CPR_TMOD - 1);
   endproperty
   a_entry_wait: assert property (p_entry_wait)
      else $error("read too soon after mode register set");
   property p_reads_only;
      mode_reg && cmd_valid |-> rd || (mrs3 && !addr[CPR_MR3_EN]);
   endproperty
   a_reads_only: assert property (p_reads_only)
      else $error("non-read command in pattern mode");
   property p_col_zero;
      rd && mode_reg |-> addr[1:0] == 2'h0 && !rst_cmd;
   endproperty
   a_col_zero: assert property (p_col_zero)
      else $error("low column bits not zero");
   property p_locked;
      cmd_valid |-> dll_locked;
   endproperty
   a_locked: assert property (p_locked)
      else $error("command before lock");
   property p_exit;
      mrs3 && !addr[CPR_MR3_EN] && mode_reg |-> !dq_oe;
   endproperty
   a_exit: assert property (p_exit)
      else $error("mode exit during burst");
endmodule
`default_nettype wire

// ===== cpr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cpr_link_if;
   logic [2:0]  cmd;
   logic [2:0]  ba;
   logic [12:0] addr;
   logic        cmd_valid;
   logic        rst_cmd;
   logic [15:0] dq_out;
   logic        dq_oe;
   logic [15:0] dq_in;
   logic        dll_locked;
   modport device (input cmd, ba, addr, cmd_valid, rst_cmd, dq_in,
                   output dq_out, dq_oe, dll_locked);
   modport ctrl   (output cmd, ba, addr, cmd_valid, rst_cmd, dq_in,
                   input dq_out, dq_oe, dll_locked);
endinterface
`default_nettype wire

// ===== cpr_pkg.sv
package cpr_pkg;
   // ==========================================================
   // Command encodings on the simplified command bus
   localparam logic [2:0] CPR_CMD_NOP  = 3'h0;
   localparam logic [2:0] CPR_CMD_MRS  = 3'h1;
   localparam logic [2:0] CPR_CMD_RD   = 3'h2;
   localparam logic [2:0] CPR_CMD_RDA  = 3'h3;
   localparam logic [2:0] CPR_CMD_WR   = 3'h4;
   localparam logic [2:0] CPR_CMD_PREA = 3'h5;
   // ==========================================================
   // Mode register selects and fields
   localparam logic [2:0] CPR_MR0      = 3'h0;
   localparam logic [2:0] CPR_MR3      = 3'h3;
   localparam int         CPR_MR3_EN   = 2;
   localparam int         CPR_MR0_BL0  = 0;
   localparam int         CPR_A_BC     = 12;
   localparam int         CPR_A_NIB    = 2;
   localparam logic [1:0] CPR_BL_FIX8  = 2'h0;
   localparam logic [1:0] CPR_BL_OTF   = 2'h1;
   localparam logic [1:0] CPR_BL_FIX4  = 2'h2;
   localparam logic [1:0] CPR_LOC_CAL  = 2'h0;
   localparam logic [7:0] CPR_CAL_PAT  = 8'haa;
   localparam logic [7:0] CPR_RFU_PAT  = 8'h00;
   // ==========================================================
   // Timing counts, in core_clk cycles
   localparam int         CPR_RL_DEF   = 6;
   localparam int         CPR_TRP      = 6;
   localparam int         CPR_TMRD     = 4;
   localparam int         CPR_TMOD     = 12;
   localparam int         CPR_PATTERN_READ_RECOVERY_TIME    = 1;
   localparam int         CPR_BURST8   = 8;
   localparam int         CPR_BURST4   = 4;
endpackage

// ===== dram_read_calibration_pattern_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dram_read_calibration_pattern_tb;
   import cpr_pkg::*;
`define CHECK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic        cal_start = 1'b0;
   logic [1:0]  cal_count = 2'h0;
   logic        cal_chop = 1'b0;
   logic        beat_ready = 1'b1;
   logic        cal_busy;
   logic [15:0] beat_data;
   logic        beat_valid;
   logic        pattern_mode;
   logic        array_rd_done;
   logic        saw_arr = 1'b0;
   int          errors = 0;
   int          tests_run = 0;
   cpr_link_if link();
   cpr_device i_cpr_device (.core_clk(core_clk), .reset(reset), .link(link.device),
      .pattern_mode(pattern_mode), .array_rd_done(array_rd_done));
   cpr_ctrl i_cpr_ctrl (.core_clk(core_clk), .reset(reset), .link(link.ctrl),
      .cal_start(cal_start), .cal_count(cal_count), .cal_chop(cal_chop),
      .cal_busy(cal_busy), .beat_data(beat_data), .beat_valid(beat_valid),
      .beat_ready(beat_ready));
   cpr_link_asserts i_cpr_link_asserts (.core_clk(core_clk), .reset(reset),
      .cmd(link.cmd), .ba(link.ba), .addr(link.addr), .cmd_valid(link.cmd_valid),
      .rst_cmd(link.rst_cmd), .dq_out(link.dq_out), .dq_oe(link.dq_oe),
      .dll_locked(link.dll_locked));
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   // Array traffic must never appear during calibration
   always @(posedge core_clk) begin
      if (array_rd_done === 1'b1) saw_arr <= 1'b1;
   end
   // ==========================================================
   // Tasks
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wait_for(input int which, input int lim);
      int n;
      n = 0;
      while (n < lim && !((which == 0 && link.dll_locked === 1'b1) ||
             (which == 1 && cal_busy === 1'b1) || (which == 2 && cal_busy === 1'b0) ||
             (which == 3 && pattern_mode === 1'b1))) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= lim) begin
         errors++;
         tally_and_finish();
      end
   endtask
   task automatic run_cal(input logic [1:0] cnt, input logic chop, input int stall);
      int got;
      int n;
      int total;
      got = 0;
      n = 0;
      total = (int'(cnt) + 1) * (chop ? CPR_BURST4 : CPR_BURST8);
      beat_ready = (stall == 0);
      cal_count = cnt;
      cal_chop = chop;
      cal_start = 1'b1;
      wait_for(1, 100);
      cal_start = 1'b0;
      wait_for(3, 100);
      repeat (stall) @(posedge core_clk);
      #1 beat_ready = 1'b1;
      // Beat shown after an edge is taken at the next edge
      while (got < total && n < 3000) begin
         if (beat_valid === 1'b1) begin
            `CHECK("beat_data", (got % 2) ? 16'hffff : 16'h0000, beat_data)
            got++;
         end
         @(posedge core_clk);
         #1;
         n++;
      end
      wait_for(2, 400);
      `CHECK("beats", total, got)
      `CHECK("extra_beat", 1'b0, beat_valid)
      `CHECK("mode_exit", 1'b0, pattern_mode)
   endtask
   // ==========================================================
   // Sequence
   initial begin
      repeat (3) @(posedge core_clk);
      #1 reset = 1'b0;
      wait_for(0, 100);
      run_cal(2'h3, 1'b0, 0);
      run_cal(2'h1, 1'b1, 0);
      run_cal(2'h0, 1'b1, 0);
      // Far side stalls while a full FIFO of beats piles up
      run_cal(2'h3, 1'b0, 300);
      cal_start = 1'b1;
      wait_for(3, 200);
      cal_start = 1'b0;
      reset = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      `CHECK("reset_mode", 1'b0, pattern_mode)
      `CHECK("reset_oe", 1'b0, link.dq_oe)
      reset = 1'b0;
      wait_for(0, 100);
      run_cal(2'h2, 1'b1, 0);
      `CHECK("array_read", 1'b0, saw_arr)
      tally_and_finish();
   end
endmodule
`default_nettype wire
